/* core/adc_sequencing_control.sv */
// converter sequencing control with APB register file and window compare
// Notes on behaviour
// - reference_choice 0 internal, 1 supply, 2 external pin; others reserved
// - conversion clock is peripheral clock divided by 2 to 256
// - start-up delay 0,16,32,64,128,256 conversion cycles before first sample
// - the same start-up delay applies after waking from deep sleep
// - wait inter_sample_delay conversion cycles between consecutive samples
// - sampling capacitor stays open during the inter-sample delay
// - with delay variation on, delay field increments after every sample
// - delay field wraps from 0xf to 0x0 under variation
// - window mode 0 never,1 below,2 above,3 inside,4 outside
// - compare uses full 16-bit result against 16-bit thresholds
// - sampling lasts two cycles plus sample_extension cycles
// - input codes 0x00..0x0b select pins 0..11; unlisted reserved
// - codes 0x1b..0x1f select internal sources down to ground
// - input change mid-conversion takes effect after it finishes
// - writing start begins a measurement; bit reads 1 until done
// - continuous mode restarts right after each completed conversion
// - accumulate 1 to 64 samples per conversion; code 7 reserved
`timescale 1ns/1ns
module adc_sequencing_control (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [9:0]  SAMPLE_DATA,
  output adc_seq_pkg::analog_ctl_t ANALOG_CTL,
  output logic             RESULT_READY,
  output logic             WINDOW_HIT
);
  // software registers
  logic [7:0]  ref_clk_q, ref_clk_d;
  logic [7:0]  delay_q, delay_d;
  logic [2:0]  wmode_q, wmode_d;
  logic [4:0]  samp_len_q, samp_len_d;
  logic [4:0]  input_q, input_d;
  logic [7:0]  ctl_q, ctl_d;
  logic [15:0] low_q, low_d;
  logic [15:0] high_q, high_d;
  logic        ready_q, ready_d;
  logic        hit_q, hit_d;
  // sequencer state
  adc_seq_pkg::seq_state_t state_q, state_d;
  logic [8:0]  cnt_q, cnt_d;
  logic [6:0]  left_q, left_d;
  logic [15:0] acc_q, acc_d;
  logic [15:0] result_q, result_d;
  logic [4:0]  active_in_q, active_in_d;
  logic [1:0]  last_ref_q, last_ref_d;
  logic        was_en_q, was_en_d;
  logic        busy_q, busy_d;
  logic        pready_q, pready_d;
  logic        perr_q, perr_d;
  logic [31:0] prdata_q, prdata_d;
  logic        tick;
  logic        access;
  logic        wr;
  logic [2:0]  init_code;
  logic [8:0]  init_cycles;
  logic [6:0]  accum_total;
  logic        legal_in;
  logic [7:0]  reg_idx;

  // conversion clock runs only while enabled
  clock_divider u_div (
    .clk                (CORE_CLK),
    .rst_n              (RSTN),
    .run                (ctl_q[adc_seq_pkg::ENABLE_BIT]),
    .clock_divider_code (ref_clk_q[adc_seq_pkg::DIV_LSB +: 3]),
    .tick               (tick)
  );

  assign access = PSEL && PENABLE && pready_q;
  assign wr = access && PWRITE;
  // word bus: unaligned addresses decode to no register and answer an error
  assign reg_idx = (PADDR[1:0] == 2'b00) ? {2'b00, PADDR[7:2]} : 8'hff;

  // decoded timing figures; reserved codes clamp to the longest legal value
  always_comb begin
    init_code = delay_q[adc_seq_pkg::STARTUP_LSB +: 3];
    if (init_code > adc_seq_pkg::STARTUP_MAX) begin
      init_code = adc_seq_pkg::STARTUP_MAX;
    end
    init_cycles = (init_code == 3'h0) ? 9'h000
                  : 9'((10'h008 << init_code));
    accum_total = 7'h01 << ((ctl_q[adc_seq_pkg::ACCUM_LSB +: 3]
                  > adc_seq_pkg::ACCUM_MAX) ? adc_seq_pkg::ACCUM_MAX
                  : ctl_q[adc_seq_pkg::ACCUM_LSB +: 3]);
    legal_in = (input_q <= adc_seq_pkg::INPUT_PIN_MAX)
               || (input_q >= adc_seq_pkg::INPUT_INT_MIN);
  end

  // window decision on the finished 16-bit sum
  function automatic logic window_check(input logic [2:0] m,
                                        input logic [15:0] r,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    logic res;
    res = 1'b0;
    unique case (m)
      3'h1:    res = r < lo;
      3'h2:    res = r > hi;
      3'h3:    res = (r > lo) && (r < hi);
      3'h4:    res = (r < lo) || (r > hi);
      default: res = 1'b0;
    endcase
    return res;
  endfunction : window_check

  // sequencer next state and register writes
  always_comb begin
    logic start_req;
    logic [3:0] sd;
    start_req = 1'b0;
    state_d = state_q;
    cnt_d = cnt_q;
    left_d = left_q;
    acc_d = acc_q;
    result_d = result_q;
    active_in_d = active_in_q;
    last_ref_d = ref_clk_q[adc_seq_pkg::REF_LSB +: 2];
    was_en_d = ctl_q[adc_seq_pkg::ENABLE_BIT];
    busy_d = busy_q;
    ready_d = ready_q;
    hit_d = hit_q;
    ref_clk_d = ref_clk_q;
    delay_d = delay_q;
    wmode_d = wmode_q;
    samp_len_d = samp_len_q;
    input_d = input_q;
    ctl_d = ctl_q;
    low_d = low_q;
    high_d = high_q;
    sd = delay_q[adc_seq_pkg::DELAY_LSB +: 4];
    if (wr) begin
      unique case (reg_idx)
        adc_seq_pkg::IDX_REF_CLOCK:    ref_clk_d = PWDATA[7:0] & 8'h37;
        adc_seq_pkg::IDX_DELAY:        delay_d = PWDATA[7:0];
        adc_seq_pkg::IDX_WINDOW_MODE:  wmode_d = PWDATA[2:0];
        adc_seq_pkg::IDX_SAMPLE_LEN:   samp_len_d = PWDATA[4:0];
        adc_seq_pkg::IDX_INPUT_SELECT: input_d = PWDATA[4:0];
        adc_seq_pkg::IDX_CONTROL:      ctl_d = PWDATA[7:0] & 8'h3f;
        adc_seq_pkg::IDX_LOW_THRESH:   low_d = PWDATA[15:0];
        adc_seq_pkg::IDX_HIGH_THRESH:  high_d = PWDATA[15:0];
        adc_seq_pkg::IDX_COMMAND:
          start_req = PWDATA[adc_seq_pkg::START_BIT];
        adc_seq_pkg::IDX_STATUS: begin
          // write one to clear; a same-cycle set below still wins
          if (PWDATA[adc_seq_pkg::READY_BIT]) ready_d = 1'b0;
          if (PWDATA[adc_seq_pkg::HIT_BIT]) hit_d = 1'b0;
        end
        default: ;
      endcase
    end
    // enabling, switching to internal reference or waking restarts warm-up
    if ((ctl_q[adc_seq_pkg::ENABLE_BIT] && !was_en_q)
        || (ref_clk_q[adc_seq_pkg::REF_LSB +: 2] == adc_seq_pkg::REF_INTERNAL
            && last_ref_q != adc_seq_pkg::REF_INTERNAL)
        || ctl_q[adc_seq_pkg::WAKE_BIT]) begin
      // abandon the running sequence, except where a same-cycle tick ends its current phase, so busy can never stick while idle
      busy_d = 1'b0;
      state_d = adc_seq_pkg::ST_IDLE;
      cnt_d = 9'h000;
      if (ctl_q[adc_seq_pkg::WAKE_BIT]) ctl_d[adc_seq_pkg::WAKE_BIT] = 1'b0;
    end
    if (!ctl_q[adc_seq_pkg::ENABLE_BIT]) begin
      state_d = adc_seq_pkg::ST_IDLE;
      busy_d = 1'b0;
    end else if (start_req && !busy_q) begin
      busy_d = 1'b1;
      state_d = adc_seq_pkg::ST_STARTUP;
      cnt_d = 9'h000;
      left_d = accum_total;
      acc_d = 16'h0000;
      active_in_d = legal_in ? input_q : adc_seq_pkg::INPUT_GROUND;
    end else if (tick) begin
      cnt_d = cnt_q + 9'h001;
      unique case (state_q)
        adc_seq_pkg::ST_IDLE: cnt_d = 9'h000;
        adc_seq_pkg::ST_STARTUP:
          // the partial tick after the start does not count as delay
          if (cnt_q >= init_cycles) begin
            state_d = adc_seq_pkg::ST_SAMPLE;
            cnt_d = 9'h000;
          end
        adc_seq_pkg::ST_SAMPLE:
          if (cnt_q + 9'h001 >= 9'(adc_seq_pkg::BASE_SAMPLE_CYCLES)
                                + 9'(samp_len_q)) begin
            state_d = adc_seq_pkg::ST_CONVERT;
            cnt_d = 9'h000;
          end
        adc_seq_pkg::ST_CONVERT:
          if (cnt_q + 9'h001 >= 9'(adc_seq_pkg::CONVERT_CYCLES)) begin
            acc_d = acc_q + 16'(SAMPLE_DATA);
            left_d = left_q - 7'h01;
            cnt_d = 9'h000;
            if (delay_q[adc_seq_pkg::VARY_BIT]) begin
              delay_d[adc_seq_pkg::DELAY_LSB +: 4] = sd + 4'h1;
            end
            if (left_q == 7'h01) begin
              result_d = acc_q + 16'(SAMPLE_DATA);
              ready_d = 1'b1;
              if (window_check(wmode_q, acc_q + 16'(SAMPLE_DATA),
                               low_q, high_q)) begin
                hit_d = 1'b1;
              end
              if (ctl_q[adc_seq_pkg::CONT_BIT]) begin
                left_d = accum_total;
                acc_d = 16'h0000;
                active_in_d = legal_in ? input_q : adc_seq_pkg::INPUT_GROUND;
                state_d = (sd == 4'h0) ? adc_seq_pkg::ST_SAMPLE
                                       : adc_seq_pkg::ST_GAP;
              end else begin
                state_d = adc_seq_pkg::ST_IDLE;
                busy_d = 1'b0;
              end
            end else begin
              state_d = (sd == 4'h0) ? adc_seq_pkg::ST_SAMPLE
                                     : adc_seq_pkg::ST_GAP;
            end
          end
        adc_seq_pkg::ST_GAP:
          if (cnt_q + 9'h001 >= 9'(sd)) begin
            state_d = adc_seq_pkg::ST_SAMPLE;
            cnt_d = 9'h000;
          end
        default: state_d = adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // read mux and bus answer: no wait state, ready in the first access cycle
  always_comb begin
    pready_d = PSEL && !pready_q;
    perr_d = 1'b0;
    prdata_d = 32'h00000000;
    if (PSEL && !pready_q) begin
      unique case (reg_idx)
        adc_seq_pkg::IDX_REF_CLOCK:    prdata_d[7:0] = ref_clk_q;
        adc_seq_pkg::IDX_DELAY:        prdata_d[7:0] = delay_q;
        adc_seq_pkg::IDX_WINDOW_MODE:  prdata_d[2:0] = wmode_q;
        adc_seq_pkg::IDX_SAMPLE_LEN:   prdata_d[4:0] = samp_len_q;
        adc_seq_pkg::IDX_INPUT_SELECT: prdata_d[4:0] = input_q;
        adc_seq_pkg::IDX_COMMAND:      prdata_d[0] = busy_q;
        adc_seq_pkg::IDX_CONTROL:      prdata_d[7:0] = ctl_q;
        adc_seq_pkg::IDX_STATUS:       prdata_d[1:0] = {hit_q, ready_q};
        adc_seq_pkg::IDX_RESULT:       prdata_d[15:0] = result_q;
        adc_seq_pkg::IDX_LOW_THRESH:   prdata_d[15:0] = low_q;
        adc_seq_pkg::IDX_HIGH_THRESH:  prdata_d[15:0] = high_q;
        default:                       perr_d = 1'b1;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ref_clk_q <= adc_seq_pkg::RST_BYTE;
      delay_q <= adc_seq_pkg::RST_BYTE;
      wmode_q <= 3'h0;
      samp_len_q <= 5'h00;
      input_q <= 5'h00;
      ctl_q <= adc_seq_pkg::RST_BYTE;
      low_q <= adc_seq_pkg::RST_THRESH;
      high_q <= adc_seq_pkg::RST_THRESH;
      ready_q <= 1'b0;
      hit_q <= 1'b0;
      state_q <= adc_seq_pkg::ST_IDLE;
      cnt_q <= 9'h000;
      left_q <= 7'h00;
      acc_q <= 16'h0000;
      result_q <= 16'h0000;
      active_in_q <= 5'h00;
      last_ref_q <= 2'h0;
      was_en_q <= 1'b0;
      busy_q <= 1'b0;
      pready_q <= 1'b0;
      perr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      ref_clk_q <= ref_clk_d;
      delay_q <= delay_d;
      wmode_q <= wmode_d;
      samp_len_q <= samp_len_d;
      input_q <= input_d;
      ctl_q <= ctl_d;
      low_q <= low_d;
      high_q <= high_d;
      ready_q <= ready_d;
      hit_q <= hit_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      left_q <= left_d;
      acc_q <= acc_d;
      result_q <= result_d;
      active_in_q <= active_in_d;
      last_ref_q <= last_ref_d;
      was_en_q <= was_en_d;
      busy_q <= busy_d;
      pready_q <= pready_d;
      perr_q <= perr_d;
      prdata_q <= prdata_d;
    end
  end

  // analog drive registered so outputs come straight from flops
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ANALOG_CTL <= '0;
      RESULT_READY <= 1'b0;
      WINDOW_HIT <= 1'b0;
    end else begin
      ANALOG_CTL.sample_open <= (state_d == adc_seq_pkg::ST_SAMPLE)
                               || (state_d == adc_seq_pkg::ST_GAP);
      ANALOG_CTL.convert <= state_d == adc_seq_pkg::ST_CONVERT;
      ANALOG_CTL.reference <= ref_clk_d[adc_seq_pkg::REF_LSB +: 2];
      ANALOG_CTL.input_choice <= active_in_d;
      RESULT_READY <= ready_d;
      WINDOW_HIT <= hit_d;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = perr_q;
endmodule : adc_sequencing_control

/* core/adc_seq_pkg.sv */
// package: register map, field layouts, codes and timing for the sequencer
package adc_seq_pkg;

  // register indices; each register is one word at four times its index
  localparam logic [7:0] IDX_REF_CLOCK    = 8'h02;
  localparam logic [7:0] IDX_DELAY        = 8'h03;
  localparam logic [7:0] IDX_WINDOW_MODE  = 8'h04;
  localparam logic [7:0] IDX_SAMPLE_LEN   = 8'h05;
  localparam logic [7:0] IDX_INPUT_SELECT = 8'h06;
  localparam logic [7:0] IDX_COMMAND      = 8'h08;
  localparam logic [7:0] IDX_CONTROL      = 8'h09;
  localparam logic [7:0] IDX_STATUS       = 8'h0b;
  localparam logic [7:0] IDX_RESULT       = 8'h10;
  localparam logic [7:0] IDX_LOW_THRESH   = 8'h12;
  localparam logic [7:0] IDX_HIGH_THRESH  = 8'h14;

  // reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_THRESH = 16'h0000;

  // field positions
  localparam int REF_LSB     = 4;
  localparam int DIV_LSB     = 0;
  localparam int STARTUP_LSB = 5;
  localparam int VARY_BIT    = 4;
  localparam int DELAY_LSB   = 0;
  localparam int ENABLE_BIT  = 0;
  localparam int CONT_BIT    = 1;
  localparam int ACCUM_LSB   = 2;
  localparam int WAKE_BIT    = 5;
  localparam int START_BIT   = 0;
  localparam int READY_BIT   = 0;
  localparam int HIT_BIT     = 1;

  // codes
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [2:0] STARTUP_MAX  = 3'h5;
  localparam logic [2:0] ACCUM_MAX    = 3'h6;
  localparam logic [4:0] INPUT_PIN_MAX = 5'h0b;
  localparam logic [4:0] INPUT_INT_MIN = 5'h1b;
  localparam logic [4:0] INPUT_GROUND  = 5'h1f;

  // timing; sample and convert lengths in conversion clock cycles
  localparam logic [4:0] BASE_SAMPLE_CYCLES = 5'h02;
  localparam logic [3:0] CONVERT_CYCLES     = 4'ha;
  localparam int SETUP_NS = 50;
  localparam int CLK_MHZ  = 20;
  localparam int SETUP_CYCLES = (SETUP_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_STARTUP = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b011,
    ST_GAP     = 3'b100
  } seq_state_t;

  // analog core drive
  typedef struct packed {
    logic       sample_open;
    logic       convert;
    logic [1:0] reference;
    logic [4:0] input_choice;
  } analog_ctl_t;

endpackage : adc_seq_pkg

/* core/clock_divider.sv */
// conversion clock tick generator: one tick per divided period
`timescale 1ns/1ns
module clock_divider (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] clock_divider_code,
  output logic            tick
);
  logic [7:0] count_q, count_d;
  logic       tick_d;

  // period is 2 << code peripheral clocks
  always_comb begin
    logic [7:0] last;
    last = 8'(9'((9'h002 << clock_divider_code) - 9'h001));
    count_d = count_q + 8'h01;
    tick_d = 1'b0;
    if (!run) begin
      count_d = 8'h00;
    end else if (count_q >= last) begin
      count_d = 8'h00;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 8'h00;
      tick    <= 1'b0;
    end else begin
      count_q <= count_d;
      tick    <= tick_d;
    end
  end
endmodule : clock_divider

/* tb/adc_sequencing_control_monitor.sv */
// checker: bus handshake and analog drive relations of the sequencer
`timescale 1ns/1ns
module adc_sequencing_control_monitor (
  input wire logic                     CORE_CLK,
  input wire logic                     RSTN,
  input wire logic                     PSEL,
  input wire logic                     PENABLE,
  input wire logic                     PWRITE,
  input wire logic [7:0]               PADDR,
  input wire logic [31:0]              PWDATA,
  input wire logic [31:0]              PRDATA,
  input wire logic                     PREADY,
  input wire logic                     PSLVERR,
  input wire logic [9:0]               SAMPLE_DATA,
  input wire adc_seq_pkg::analog_ctl_t ANALOG_CTL,
  input wire logic                     RESULT_READY,
  input wire logic                     WINDOW_HIT
);
  int conv_len_q;

  // convert phase length; ten divided cycles at divide-by-2 is the floor
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) conv_len_q <= 0;
    else if (ANALOG_CTL.convert) conv_len_q <= conv_len_q + 1;
    else conv_len_q <= 0;
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_setup; PSEL && !PENABLE && !PREADY; endsequence
  sequence s_access; PSEL && PENABLE && PREADY; endsequence

  property p_answer; s_setup |=> s_access; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_pulse; PREADY |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_err; PSLVERR |-> s_access; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_min_sample;
    $rose(ANALOG_CTL.sample_open) |-> ANALOG_CTL.sample_open[*4];
  endproperty
  a_min_sample: assert property (p_min_sample)
    else $error("sampling shorter than two divided cycles");
  property p_excl; !(ANALOG_CTL.sample_open && ANALOG_CTL.convert); endproperty
  a_excl: assert property (p_excl)
    else $error("sampling and converting at once");
  property p_input_legal;
    ANALOG_CTL.input_choice <= 5'h0b || ANALOG_CTL.input_choice >= 5'h1b;
  endproperty
  a_input_legal: assert property (p_input_legal)
    else $error("reserved input routed");
  property p_input_hold;
    ANALOG_CTL.convert && $past(ANALOG_CTL.convert)
      |-> $stable(ANALOG_CTL.input_choice);
  endproperty
  a_input_hold: assert property (p_input_hold)
    else $error("input changed while converting");
  property p_convert_len; $fell(ANALOG_CTL.convert) |-> conv_len_q >= 20;
  endproperty
  a_convert_len: assert property (p_convert_len)
    else $error("convert phase too short");
  property p_hit_done; $rose(WINDOW_HIT) |-> RESULT_READY; endproperty
  a_hit_done: assert property (p_hit_done)
    else $error("hit set without completed result");
endmodule : adc_sequencing_control_monitor

bind adc_sequencing_control adc_sequencing_control_monitor u_monitor (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE_DATA(SAMPLE_DATA),
  .ANALOG_CTL(ANALOG_CTL), .RESULT_READY(RESULT_READY),
  .WINDOW_HIT(WINDOW_HIT));

/* tb/analog_core_model.sv */
// far-side model: input multiplexer plus converter core
`timescale 1ns/1ns
module analog_core_model (
  input wire logic                     clk,
  input wire adc_seq_pkg::analog_ctl_t ctl,
  output logic [9:0]                   sample_data
);
  logic [9:0] idle_q = 10'h155;

  // code carries the input number, so a wrong route shows in the result
  assign sample_data = ctl.convert ? {ctl.input_choice, 5'h05} : idle_q;
  // toggles outside a conversion so a stale read never matches
  always @(posedge clk) idle_q <= ~sample_data;
endmodule : analog_core_model

/* tb/adc_sequencing_control_tb.sv */
// testbench: register access, timing, window and sequencing scenarios
`timescale 1ns/1ns
module adc_sequencing_control_tb;
  logic                     core_clk, rstn, psel, penable, pwrite;
  logic                     pready, pslverr, result_ready, window_hit;
  logic                     err, prev_open;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic [9:0]               sample_data;
  adc_seq_pkg::analog_ctl_t ctl, first_ctl;
  int                       mismatches, tests_run, cyc, open_cnt;
  int                       rise_cyc, t0, lat0;
  int                       lens[$];
  logic [4:0]               in_tab[8] = '{5'h00, 5'h0b, 5'h1b, 5'h1c,
                                          5'h1d, 5'h1e, 5'h1f, 5'h10};
  logic [15:0]              lo_tab[4] = '{16'h66, 16'h64, 16'h64, 16'h0};
  logic [15:0]              hi_tab[4] = '{16'h100, 16'h65, 16'h66, 16'h64};

  adc_sequencing_control u_adc_sequencing_control (
    .CORE_CLK(core_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SAMPLE_DATA(sample_data),
    .ANALOG_CTL(ctl), .RESULT_READY(result_ready), .WINDOW_HIT(window_hit));
  analog_core_model u_analog_core_model (
    .clk(core_clk), .ctl(ctl), .sample_data(sample_data));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic complete_run;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // pulse lengths and drive at each sampling start; also the hang limit
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    prev_open <= ctl.sample_open;
    if (ctl.sample_open && !prev_open) begin
      first_ctl <= ctl;
      rise_cyc  <= cyc;
    end
    if (ctl.sample_open) open_cnt <= open_cnt + 1;
    else if (open_cnt != 0) begin
      lens.push_back(open_cnt);
      open_cnt <= 0;
    end
    if (cyc > 30000) begin
      mismatches++;
      complete_run;
    end
  end

  task automatic cmp(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // one bus transfer; held until ready is seen, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, string s);
    apb(1'b0, a, 32'h0);
    cmp(s, e, rd);
  endtask : rdc

  task automatic wait_ready;
    while (result_ready !== 1'b1) @(posedge core_clk);
    cmp("ready", 32'h1, {31'h0, result_ready});
  endtask : wait_ready

  // clear flags, start one measurement, wait for its result
  task automatic conv;
    wr(8'h2c, 32'h3);
    lens.delete();
    wr(8'h20, 32'h1);
    t0 = cyc;
    wait_ready;
  endtask : conv

  function automatic logic exp_hit(input logic [2:0] m,
                                   input logic [15:0] r, lo, hi);
    case (m)
      3'h1: return r < lo;
      3'h2: return r > hi;
      3'h3: return (r > lo) && (r < hi);
      3'h4: return (r < lo) || (r > hi);
      default: return 1'b0;
    endcase
  endfunction : exp_hit

  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    for (int a = 2; a < 7; a++) rdc(8'(a * 4), 32'h0, "reset value");
    apb(1'b0, 8'h1c, 32'h0);
    cmp("unmapped error", 32'h1, {31'h0, err});
    apb(1'b0, 8'h0d, 32'h0);
    cmp("unaligned error", 32'h1, {31'h0, err});
    wr(8'h14, 32'h1f);
    rdc(8'h14, 32'h1f, "sample length");
    wr(8'h14, 32'h0);
    wr(8'h24, 32'h1);
    // reference codes 0 to 2, both pin ends, internal codes and reserved 0x10, seen at the start of sampling
    for (int i = 0; i < 8; i++) begin
      wr(8'h08, {26'h0, 2'(i % 3), 4'h0});
      wr(8'h18, {27'h0, in_tab[i]});
      conv;
      cmp("reference", 32'(i % 3), {30'h0, first_ctl.reference});
      cmp("input", (i == 7) ? 32'h1f : {27'h0, in_tab[i]},
          {27'h0, first_ctl.input_choice});
    end
    wr(8'h18, 32'h3);
    // divide by 4 with 3 extra cycles, then the plain two cycles
    wr(8'h08, 32'h1);
    wr(8'h14, 32'h3);
    conv;
    cmp("sample span", 32'd20, 32'(lens[0]));
    wr(8'h08, 32'h0);
    wr(8'h14, 32'h0);
    conv;
    cmp("sample span", 32'd4, 32'(lens[0]));
    // same lead-in before every timed start keeps the divider phase equal
    wr(8'h0c, 32'h0);
    conv;
    lat0 = rise_cyc - t0;
    wr(8'h0c, 32'h20);
    conv;
    cmp("startup", 32'(lat0 + 32), 32'(rise_cyc - t0));
    // a wake pulse clears itself and the next start still warms up
    wr(8'h24, 32'h21);
    conv;
    cmp("wake startup", 32'(lat0 + 32), 32'(rise_cyc - t0));
    rdc(8'h24, 32'h1, "wake clear");
    wr(8'h0c, 32'h0);
    // window modes against thresholds around the result 0x0065
    for (int p = 0; p < 4; p++) begin
      wr(8'h48, {16'h0, lo_tab[p]});
      wr(8'h50, {16'h0, hi_tab[p]});
      for (int m = 0; m < 5; m++) begin
        wr(8'h10, 32'(m));
        conv;
        cmp("hit", {31'h0, exp_hit(3'(m), 16'h65, lo_tab[p], hi_tab[p])},
            {31'h0, window_hit});
      end
    end
    wr(8'h10, 32'h0);
    // two samples with a gap; input rewritten inside the conversion
    wr(8'h0c, 32'h05);
    wr(8'h24, 32'h05);
    wr(8'h2c, 32'h3);
    lens.delete();
    wr(8'h20, 32'h1);
    while (ctl.convert !== 1'b1) @(posedge core_clk);
    wr(8'h18, 32'h5);
    rdc(8'h20, 32'h1, "busy");
    wait_ready;
    rdc(8'h40, 32'h00ca, "result");
    cmp("gap span", 32'd14, 32'(lens[1]));
    rdc(8'h20, 32'h0, "busy");
    // delay variation wraps the field after one sample
    wr(8'h24, 32'h1);
    wr(8'h0c, 32'h1f);
    conv;
    rdc(8'h0c, 32'h10, "delay field");
    wr(8'h0c, 32'h0);
    // continuous mode delivers a second result with no second start
    wr(8'h24, 32'h3);
    conv;
    wr(8'h2c, 32'h3);
    cmp("ready cleared", 32'h0, {31'h0, result_ready});
    wait_ready;
    wr(8'h24, 32'h1);
    complete_run;
  end
endmodule : adc_sequencing_control_tb
